// file: ddsc_core.sv
// Two-wire slave, channel select and double-buffered registers for a dual DAC
`timescale 1ns/1ns
module ddsc_core import ddsc_pkg::*; #(
  parameter int DAC_BITS = 12,
  parameter bit ALT_ADDRESS = 1'b0,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addressStrapLsb,
  output logic [DAC_BITS-1:0] dacCodeA,
  output logic [DAC_BITS-1:0] dacCodeB,
  output ddsc_power_type powerModeA,
  output ddsc_power_type powerModeB
);

  // Only the documented resolutions are served
  if (DAC_BITS != 8 && DAC_BITS != 10 && DAC_BITS != 12) begin : g_bad_bits
    $error("ddsc_core resolution must be 8, 10 or 12");
  end

  // Left-justified code bits kept in a stored word
  localparam logic [15:0] CODE_MASK = 16'(((32'h1 << DAC_BITS) - 32'h1) << (CODE_MSB + 1 - DAC_BITS));
  localparam logic [15:0] WORD_KEEP = CTRL_MASK | CODE_MASK;

  // Input synchronisers and edge history
  logic sclMeta_reg;  // First stage, read only by the second
  logic sclSync_reg;  // Synchronised clock level
  logic sclPrev_reg;  // Previous synchronised level
  logic sdaMeta_reg;
  logic sdaSync_reg;
  logic sdaPrev_reg;
  logic strapMeta_reg;
  logic strapSync_reg;

  // Serial engine state
  ddsc_state_type state_reg, state_next;
  logic [3:0] bitCnt_reg, bitCnt_next;  // Bits seen in current byte
  logic [7:0] rxShift_reg, rxShift_next;  // Receive shifter
  logic [1:0] byteIdx_reg, byteIdx_next;  // Position in write transaction
  logic [7:0] dataHi_reg, dataHi_next;  // First data byte held until second arrives
  logic [1:0] pointer_reg, pointer_next;  // Stored channel selection
  logic sdaOe_reg, sdaOe_next;  // Pull data line low
  logic sdaOut_reg;  // Always low, open-drain
  logic ackToTx_reg, ackToTx_next;  // Acknowledge slot leads into transmit
  logic [15:0] txWord_reg, txWord_next;  // Readback word being sent
  logic [3:0] txPos_reg, txPos_next;  // Bit index of word being sent

  // Per-channel registers
  logic [15:0] inWord_reg [2];  // Input registers with control bits
  logic [DAC_BITS-1:0] dacCode_reg [2];  // DAC registers
  ddsc_power_type power_reg [2];  // Output stage modes

  // FIFO between serial engine and register bank
  ddsc_write_type pushData;
  ddsc_write_type popData;
  logic fifoInReady;
  logic fifoOutValid;

  // Edge and bus condition decode on synchronised levels
  wire sclRise = sclSync_reg && !sclPrev_reg;
  wire sclFall = !sclSync_reg && sclPrev_reg;
  wire sclHigh = sclSync_reg && sclPrev_reg;
  wire startDet = sclHigh && sdaPrev_reg && !sdaSync_reg;
  wire stopDet = sclHigh && !sdaPrev_reg && sdaSync_reg;
  wire [6:0] ownAddr = {(ALT_ADDRESS ? ADDR_HI_ALT : ADDR_HI_STD), strapSync_reg};
  wire byteDone = sclFall && (bitCnt_reg == BYTE_BITS);
  wire addrDone = (state_reg == ST_ADDR) && byteDone;
  wire addrMatch = rxShift_reg[7:1] == ownAddr;
  wire rxDone = (state_reg == ST_RX) && byteDone;
  wire fifoPush = rxDone && (byteIdx_reg == IDX_LO) && fifoInReady;
  wire [3:0] txPosDec = txPos_reg - 4'h1;

  // Readback selection: one channel gives its word, none or both the default
  wire selOnlyA = pointer_reg == 2'h1;
  wire selOnlyB = pointer_reg == 2'h2;
  wire [15:0] readWord = selOnlyA ? inWord_reg[PTR_A] :
                         selOnlyB ? inWord_reg[PTR_B] : READ_DEFAULT;

  // Drain only while the serial engine is idle so updates never overlap a write to this device
  wire popReady = state_reg == ST_IDLE;
  wire popFire = fifoOutValid && popReady;
  wire popClear = !popData.word[CLR_BIT];
  wire popLoad = !popData.word[LOAD_OUTPUTS_N_BIT];

  assign pushData.sel = pointer_reg;
  assign pushData.word = {dataHi_reg, rxShift_reg};

  // Outputs straight from flip-flops
  assign sdaOut = sdaOut_reg;
  assign sdaOe = sdaOe_reg;
  assign dacCodeA = dacCode_reg[PTR_A];
  assign dacCodeB = dacCode_reg[PTR_B];
  assign powerModeA = power_reg[PTR_A];
  assign powerModeB = power_reg[PTR_B];

  // Two-stage synchronisers for pins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {sclMeta_reg, sclSync_reg, sclPrev_reg} <= 3'h7;
      {sdaMeta_reg, sdaSync_reg, sdaPrev_reg} <= 3'h7;
      {strapMeta_reg, strapSync_reg} <= 2'h0;
    end else begin
      {sclMeta_reg, sclSync_reg, sclPrev_reg} <= {sclIn, sclMeta_reg, sclSync_reg};
      {sdaMeta_reg, sdaSync_reg, sdaPrev_reg} <= {sdaIn, sdaMeta_reg, sdaSync_reg};
      {strapMeta_reg, strapSync_reg} <= {addressStrapLsb, strapMeta_reg};
    end
  end

  // Serial engine next state; the clock line is only ever sampled
  always_comb begin
    state_next = state_reg;
    bitCnt_next = bitCnt_reg;
    rxShift_next = rxShift_reg;
    byteIdx_next = byteIdx_reg;
    dataHi_next = dataHi_reg;
    pointer_next = pointer_reg;
    sdaOe_next = sdaOe_reg;
    ackToTx_next = ackToTx_reg;
    txWord_next = txWord_reg;
    txPos_next = txPos_reg;
    if (startDet) begin
      // Start or repeated start abandons any partial word
      state_next = ST_ADDR;
      bitCnt_next = 4'h0;
      sdaOe_next = 1'b0;
    end else if (stopDet) begin
      // Stop returns to idle, partial word dropped
      state_next = ST_IDLE;
      sdaOe_next = 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_RX: begin
          // Sample on rising clock, eight bits per byte
          if (sclRise && bitCnt_reg != BYTE_BITS) begin
            rxShift_next = {rxShift_reg[6:0], sdaSync_reg};
            bitCnt_next = bitCnt_reg + 4'h1;
          end
          if (addrDone) begin
            if (addrMatch) begin
              // Acknowledge and prepare readback with stored selection
              state_next = ST_ACK;
              sdaOe_next = 1'b1;
              ackToTx_next = rxShift_reg[0];
              byteIdx_next = IDX_PTR;
              txWord_next = readWord;
              txPos_next = 4'hf;
            end else begin
              // Other address: leave the bus alone
              state_next = ST_IDLE;
            end
          end
          if (rxDone) begin
            state_next = ST_ACK;
            ackToTx_next = 1'b0;
            // Refuse the second data byte if the buffer is full
            sdaOe_next = !((byteIdx_reg == IDX_LO) && !fifoInReady);
            case (byteIdx_reg)
              IDX_PTR: begin
                pointer_next = rxShift_reg[1:0];
                byteIdx_next = IDX_HI;
              end
              IDX_HI: begin
                dataHi_next = rxShift_reg;
                byteIdx_next = IDX_LO;
              end
              default: begin
                byteIdx_next = IDX_HI;
              end
            endcase
          end
        end
        ST_ACK: begin
          // Release after the ninth pulse, drive first read bit while low
          if (sclFall) begin
            bitCnt_next = 4'h0;
            if (ackToTx_reg) begin
              state_next = ST_TX;
              sdaOe_next = !txWord_reg[txPos_reg];
            end else begin
              state_next = ST_RX;
              sdaOe_next = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (sclRise) begin
            bitCnt_next = bitCnt_reg + 4'h1;
          end
          if (sclFall) begin
            txPos_next = txPosDec;
            if (bitCnt_reg == BYTE_BITS) begin
              state_next = ST_TACK;
              sdaOe_next = 1'b0;
            end else begin
              sdaOe_next = !txWord_reg[txPosDec];
            end
          end
        end
        ST_TACK: begin
          // Master acknowledge continues, words repeat after wrap
          if (sclRise && sdaSync_reg) begin
            state_next = ST_IDLE;
          end else if (sclFall) begin
            state_next = ST_TX;
            bitCnt_next = 4'h0;
            sdaOe_next = !txWord_reg[txPos_reg];
          end
        end
        ST_IDLE: begin
          sdaOe_next = 1'b0;
        end
        default: begin
          state_next = ST_IDLE;
          sdaOe_next = 1'b0;
        end
      endcase
    end
  end

  // Serial engine registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 4'h0;
      rxShift_reg <= 8'h00;
      byteIdx_reg <= IDX_PTR;
      dataHi_reg <= 8'h00;
      pointer_reg <= PTR_RESET[1:0];
      sdaOe_reg <= 1'b0;
      sdaOut_reg <= 1'b0;
      ackToTx_reg <= 1'b0;
      txWord_reg <= READ_DEFAULT;
      txPos_reg <= 4'hf;
    end else begin
      state_reg <= state_next;
      bitCnt_reg <= bitCnt_next;
      rxShift_reg <= rxShift_next;
      byteIdx_reg <= byteIdx_next;
      dataHi_reg <= dataHi_next;
      pointer_reg <= pointer_next;
      sdaOe_reg <= sdaOe_next;
      sdaOut_reg <= 1'b0;
      ackToTx_reg <= ackToTx_next;
      txWord_reg <= txWord_next;
      txPos_reg <= txPos_next;
    end
  end

  // Completed words wait here until the serial engine goes idle
  ddsc_fifo #(
    .WIDTH($bits(ddsc_write_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData(pushData),
    .outValid(fifoOutValid),
    .outReady(popReady),
    .outData(popData)
  );

  // Per-channel input register, DAC register and power mode
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    wire hit = popData.sel[ch];
    wire [15:0] inNext = popClear ? READ_DEFAULT :
                         hit ? (popData.word & WORD_KEEP) : inWord_reg[ch];
    wire [DAC_BITS-1:0] dacNext = popClear ? '0 :
                                  popLoad ? inNext[CODE_MSB -: DAC_BITS] : dacCode_reg[ch];
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        inWord_reg[ch] <= READ_DEFAULT;
        dacCode_reg[ch] <= '0;
        power_reg[ch] <= PWR_NORMAL;
      end else if (popFire) begin
        inWord_reg[ch] <= inNext;
        dacCode_reg[ch] <= dacNext;
        if (hit) begin
          power_reg[ch] <= ddsc_power_type'(popData.word[PM_HI:PM_LO]);
        end
      end
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence sAddrHit;
    addrDone && addrMatch;
  endsequence

  sequence sAckSlot;
    (state_reg == ST_ACK) && sdaOe_reg;
  endsequence

  a_addr_ack: assert property (sAddrHit |=> sAckSlot) else $error("own address not acknowledged");
  a_addr_ignore: assert property (addrDone && !addrMatch |=> state_reg == ST_IDLE && !sdaOe_reg)
    else $error("foreign address answered");
  a_idle_quiet: assert property (state_reg == ST_IDLE |-> !sdaOe_reg) else $error("bus driven while idle");
  a_change_scl_low: assert property ($changed(sdaOe_reg) |-> !sclSync_reg || $past(startDet || stopDet))
    else $error("data line changed while clock high");
  a_start_restart: assert property (startDet |=> state_reg == ST_ADDR && bitCnt_reg == 4'h0 && !sdaOe_reg)
    else $error("start not honoured");
  a_push_complete: assert property (fifoPush |-> state_reg == ST_RX && byteIdx_reg == IDX_LO && sclFall)
    else $error("word pushed before completion");
  a_clear_zeroes: assert property (popFire && popClear |=> dacCode_reg[0] == '0 && dacCode_reg[1] == '0
    && inWord_reg[0] == READ_DEFAULT && inWord_reg[1] == READ_DEFAULT) else $error("clear failed");
  a_load_both: assert property (popFire && !popClear && popLoad |=>
    dacCode_reg[0] == inWord_reg[0][CODE_MSB -: DAC_BITS] && dacCode_reg[1] == inWord_reg[1][CODE_MSB -: DAC_BITS])
    else $error("simultaneous load failed");
  a_load_hold: assert property (popFire && !popClear && !popLoad |=> $stable(dacCode_reg[0]) && $stable(dacCode_reg[1]))
    else $error("DAC register changed without load");
  a_default_read: assert property (pointer_reg == 2'h0 || pointer_reg == 2'h3 |-> readWord == READ_DEFAULT)
    else $error("default readback wrong");
  a_read_repeat: assert property (state_reg == ST_TX && $past(state_reg) == ST_TX |-> $stable(txWord_reg))
    else $error("readback word changed mid read");

endmodule

// file: ddsc_pkg.sv
// Shared constants and types for the dual DAC two-wire control block
package ddsc_pkg;

  // Upper six bits of the slave address, standard and alternate variants
  localparam logic [5:0] ADDR_HI_STD = 6'h06;
  localparam logic [5:0] ADDR_HI_ALT = 6'h11;

  // Bits per byte on the wire, before the acknowledge slot
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Channel-select byte field positions and reset value
  localparam int PTR_A = 0;
  localparam int PTR_B = 1;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Data word field positions
  localparam int PM_HI = 15;
  localparam int PM_LO = 14;
  localparam int CLR_BIT = 13;
  localparam int LOAD_OUTPUTS_N_BIT = 12;
  localparam int CODE_MSB = 11;

  // Readback word for no channel, both channels, and input register reset
  localparam logic [15:0] READ_DEFAULT = 16'h2000;

  // Control bits kept in the stored input word
  localparam logic [15:0] CTRL_MASK = 16'hf000;

  // Byte position within a write transaction
  localparam logic [1:0] IDX_PTR = 2'h0;
  localparam logic [1:0] IDX_HI = 2'h1;
  localparam logic [1:0] IDX_LO = 2'h2;

  // Output stage modes selected by the two power-mode bits
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0,
    PWR_DOWN_1K = 2'h1,
    PWR_DOWN_100K = 2'h2,
    PWR_DOWN_TRISTATE = 2'h3
  } ddsc_power_type;

  // Serial engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_RX = 6'h04,
    ST_ACK = 6'h08,
    ST_TX = 6'h10,
    ST_TACK = 6'h20
  } ddsc_state_type;

  // One completed write: channel selection and the full data word
  typedef struct packed {
    logic [1:0] sel;
    logic [15:0] word;
  } ddsc_write_type;

endpackage

// file: ddsc_fifo.sv
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ns
module ddsc_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two of at least two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("ddsc_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW:0] wrPtr_reg;  // Write pointer with wrap bit
  logic [AW:0] rdPtr_reg;  // Read pointer with wrap bit

  wire pushFire = inValid && inReady;
  wire popFire = outValid && outReady;
  wire ptrSameAddr = wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0];

  // Full when addresses meet with opposite wrap bits, empty when equal
  assign inReady = !(ptrSameAddr && (wrPtr_reg[AW] != rdPtr_reg[AW]));
  assign outValid = wrPtr_reg != rdPtr_reg;
  assign outData = mem[rdPtr_reg[AW-1:0]];

  // Pointer update
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (pushFire) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (popFire) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge clock) begin
    if (pushFire) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

endmodule

// file: ddsc_top_note_end.sv
// Holds no logic; the block lives in the core and buffer files

// file: ddsc_master.sv
// Behavioural two-wire bus master that drives the DAC control block
`timescale 1ns/1ns
module ddsc_master (
  input wire logic sdaLine,
  output logic scl,
  output logic sdaDrive
);
  // Extra low-phase time in 100 ns steps, lets the bench slow the bus
  int stretch = 0;

  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sdaDrive = 1'b0;
  end

  // One clock pulse; data changes only while the clock is low
  task automatic pulse(input logic bitVal, output logic seen);
    #400 sdaDrive = ~bitVal;
    #(100 + 100 * stretch) scl = 1'b1;
    #300 seen = sdaLine;
    #100 scl = 1'b0;
  endtask

  // Start or repeated start, leaves the clock low
  task automatic start();
    #400 sdaDrive = 1'b0;
    #100 scl = 1'b1;
    #200 sdaDrive = 1'b1;
    #200 scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    #400 sdaDrive = 1'b1;
    #100 scl = 1'b1;
    #200 sdaDrive = 1'b0;
    #400;
  endtask

  // Eight bits MSB first, then the slave's acknowledge slot
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(b[i], s);
    end
    pulse(1'b1, s);
    ack = ~s;
  endtask

  // Eight bits from the slave, then our acknowledge or not-acknowledge
  task automatic recvByte(input logic ackIt, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, s);
      b[i] = s;
    end
    pulse(~ackIt, s);
  endtask
endmodule

// file: ddsc_core_test.sv
// Self-checking bench for the dual DAC two-wire control block
`timescale 1ns/1ns
module ddsc_core_test import ddsc_pkg::*;;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic strap = 1'b0;
  logic scl;
  logic mDrive;
  logic sdaOut;
  logic sdaOe;
  logic [11:0] dacCodeA;
  logic [11:0] dacCodeB;
  ddsc_power_type powerModeA;
  ddsc_power_type powerModeB;
  // Open-drain data wire with pull-up
  wire logic sdaLine = ~((sdaOe & ~sdaOut) | mDrive);
  // Expected input words and DAC codes
  logic [15:0] inA = READ_DEFAULT;
  logic [15:0] inB = READ_DEFAULT;
  logic [11:0] expA = 12'h000;
  logic [11:0] expB = 12'h000;
  int mismatches = 0;
  int tests_run = 0;
  int seed = 79555;

  // 100 ns system clock
  always #50 clock = ~clock;

  ddsc_core #(.DAC_BITS(12), .ALT_ADDRESS(1'b0), .FIFO_DEPTH(32)) ddsc_core_inst (
    .clock(clock), .resetn(resetn), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .addressStrapLsb(strap), .dacCodeA(dacCodeA), .dacCodeB(dacCodeB),
    .powerModeA(powerModeA), .powerModeB(powerModeB));
  ddsc_master ddsc_master_inst (.sdaLine(sdaLine), .scl(scl), .sdaDrive(mDrive));

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Final report and verdict
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Own slave address from the strap
  function automatic logic [6:0] ownAddr();
    return {ADDR_HI_STD, strap};
  endfunction

  // Readback expected for a channel selection
  function automatic logic [15:0] readExp(input logic [1:0] s);
    return (s == 2'b01) ? inA : ((s == 2'b10) ? inB : READ_DEFAULT);
  endfunction

  // Reference model of one completed write
  task automatic model(input logic [1:0] sel, input logic [15:0] w);
    if (!w[CLR_BIT]) begin
      inA = READ_DEFAULT;
      inB = READ_DEFAULT;
      expA = 12'h000;
      expB = 12'h000;
    end else begin
      if (sel[PTR_A]) inA = w;
      if (sel[PTR_B]) inB = w;
      if (!w[LOAD_OUTPUTS_N_BIT]) begin
        expA = inA[11:0];
        expB = inB[11:0];
      end
    end
  endtask

  // Start, address with write direction, channel-select byte
  task automatic sendPtr(input logic [6:0] adr, input logic [7:0] ptr, output logic ok);
    logic a1;
    logic a2;
    ddsc_master_inst.start();
    ddsc_master_inst.sendByte({adr, 1'b0}, a1);
    ddsc_master_inst.sendByte(ptr, a2);
    ok = a1 & a2;
  endtask

  // Full write of one data word, then stop
  task automatic writeWord(input logic [7:0] ptr, input logic [15:0] w);
    logic ok;
    logic a1;
    logic a2;
    sendPtr(ownAddr(), ptr, ok);
    ddsc_master_inst.sendByte(w[15:8], a1);
    ddsc_master_inst.sendByte(w[7:0], a2);
    ddsc_master_inst.stop();
    check({15'h0, ok & a1 & a2}, 16'h0001, "write ack");
    model(ptr[1:0], w);
  endtask

  // Read with optional pointer, repeating the word reps times
  task automatic readCheck(input logic pointed, input logic [7:0] ptr, input int reps, input logic [15:0] exp);
    logic ok;
    logic [15:0] w;
    if (pointed) sendPtr(ownAddr(), ptr, ok);
    ddsc_master_inst.start();
    ddsc_master_inst.sendByte({ownAddr(), 1'b1}, ok);
    for (int i = 0; i < reps; i++) begin
      ddsc_master_inst.recvByte(1'b1, w[15:8]);
      ddsc_master_inst.recvByte(i < reps - 1, w[7:0]);
      check(w, exp, "readback");
    end
    ddsc_master_inst.stop();
  endtask

  // Let the deferred update land, then compare both DAC codes
  task automatic checkDacs();
    repeat (20) @(posedge clock);
    check({4'h0, dacCodeA}, {4'h0, expA}, "dac A");
    check({4'h0, dacCodeB}, {4'h0, expB}, "dac B");
    // Step off the clock edge so later bus activity never races the synchroniser
    #1;
  endtask

  // Guard against a hung run
  initial begin
    #9000000;
    mismatches++;
    $display("FAIL %0t run too long", $time);
    wrap_up();
  end

  // Main sequence
  initial begin
    int r;
    logic ok;
    logic [7:0] p;
    logic [15:0] w;
    logic [6:0] bad[3];
    repeat (4) @(posedge clock);
    #1 resetn = 1'b1;
    repeat (4) @(posedge clock);
    check({2'b00, powerModeA, dacCodeA}, 16'h0000, "reset A");
    check({2'b00, powerModeB, dacCodeB}, 16'h0000, "reset B");
    // Bus pins change 1 ns after a clock edge from here on
    #1;
    readCheck(1'b0, 8'h00, 1, READ_DEFAULT);
    strap = 1'b1;
    bad[0] = {ADDR_HI_ALT, strap};
    bad[1] = {ADDR_HI_STD, ~strap};
    bad[2] = 7'h7f;
    // Foreign addresses get no acknowledge
    foreach (bad[i]) begin
      sendPtr(bad[i], 8'h01, ok);
      ddsc_master_inst.stop();
      check({15'h0, ok}, 16'h0000, "foreign ack");
    end
    // Random writes, selections, clears and loads, each read back
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      p = {r[7:6], 4'h0, ((r[1:0] == 2'b00) ? 2'b01 : 2'(r[1:0]))};
      w = 16'($random(seed));
      w[CLR_BIT] = (i % 8 != 7);
      ddsc_master_inst.stretch = r[9:8];
      writeWord(p, w);
      checkDacs();
      readCheck(1'b1, p, 1, readExp(p[1:0]));
    end
    // Every power mode on both channels at once
    for (int m = 0; m < 4; m++) begin
      writeWord(8'h03, {2'(m), 2'b10, 12'($random(seed))});
      checkDacs();
      check({14'h0, powerModeA}, 16'(m), "power A");
      check({14'h0, powerModeB}, 16'(m), "power B");
    end
    readCheck(1'b0, 8'h00, 1, READ_DEFAULT);
    readCheck(1'b1, 8'h01, 3, inA);
    // Aborted word changes nothing
    sendPtr(ownAddr(), 8'h02, ok);
    ddsc_master_inst.sendByte(8'h3f, ok);
    ddsc_master_inst.stop();
    checkDacs();
    readCheck(1'b1, 8'h02, 1, inB);
    // Fill the buffer in one write until it refuses
    ddsc_master_inst.stretch = 2;
    sendPtr(ownAddr(), 8'h01, ok);
    for (int k = 0; k < 33; k++) begin
      w = {4'h2, 12'(k + 16)};
      ddsc_master_inst.sendByte(w[15:8], ok);
      ddsc_master_inst.sendByte(w[7:0], ok);
      check({15'h0, ok}, 16'(k < 32), "fifo ack");
      if (k < 32) model(2'b01, w);
    end
    ddsc_master_inst.stop();
    repeat (40) @(posedge clock);
    checkDacs();
    wrap_up();
  end
endmodule
